// [sso_far_model.sv]
`timescale 1ns/1ns
module sso_far_model (
    input wire logic core_clk,
    input wire logic [3:0] lvl,
    input wire logic [3:0] bad,
    input wire logic req,
    input wire logic [7:0] req_hit,
    output logic [sso_pkg::IN_N-1:0] ctl_l1,
    output logic [sso_pkg::IN_N-1:0] ctl_l2,
    output sso_pkg::sso_scan_t [sso_pkg::SENS_N-1:0] scan
);
    import sso_pkg::*;
    // ========
    // Control pairs, bad only for fault tests
    assign ctl_l2 = lvl;
    assign ctl_l1 = ~lvl ^ bad;
    // ========
    // Sensor zero scans on request
    // Idle payload toggles, so stale bits never pass as data
    initial scan = '0;
    always @(posedge core_clk) begin
        for (int i = 0; i < SENS_N; i++) begin
            scan[i].vld <= req && (i == 0);
            scan[i].hit <= req ? req_hit : ~scan[i].hit;
            scan[i].multi <= req ? req_hit : ~scan[i].multi;
        end
    end
endmodule

// [sso_out_ctl.sv]
`timescale 1ns/1ns
module sso_out_ctl #(
    parameter int SEC_CYC = sso_pkg::SEC_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input sso_pkg::sso_restart_t mode,
    input wire logic [7:0] delay_s,
    input wire logic kill,
    input wire logic trip,
    input wire logic clear,
    input wire logic restart_btn,
    output logic ossd
);
    import sso_pkg::*;

    localparam int PW = $clog2(SEC_CYC + 1);

    typedef enum logic [1:0] {S_HOLD, S_ARM, S_DELAY, S_ON} sso_ost_t;

    sso_ost_t st_q;
    logic [PW-1:0] pre_q;
    logic [7:0] sec_q;
    logic [1:0] past_st_q;

    // ==========================================================
    // Restart sequencing
    // Reset lands in hold so every mode needs a clear field first
    always_ff @(posedge core_clk) begin
        if (!rst_n || kill || trip) begin
            st_q <= S_HOLD;
        end else begin
            unique case (st_q)
                S_HOLD: begin
                    if (clear) begin
                        if (mode == RST_NODELAY) begin
                            st_q <= S_ON; // see R2
                        end else if (mode == RST_DELAYED && delay_s != 8'h00) begin
                            st_q <= S_DELAY; // see R3
                        end else if (mode == RST_DELAYED) begin
                            st_q <= S_ON;
                        end else begin
                            st_q <= S_ARM; // see R1
                        end
                    end
                end
                S_ARM: begin
                    if (restart_btn) begin
                        st_q <= S_ON; // see R1
                    end
                end
                S_DELAY: begin
                    if (sec_q == delay_s) begin
                        st_q <= S_ON; // see R3
                    end
                end
                S_ON: begin
                    st_q <= S_ON;
                end
            endcase
        end
    end

    // ==========================================================
    // Seconds timer, restarted on each entry to the delay state
    always_ff @(posedge core_clk) begin
        if (!rst_n || st_q != S_DELAY) begin
            pre_q <= '0;
            sec_q <= 8'h00;
        end else if (pre_q == PW'(SEC_CYC - 1)) begin
            pre_q <= '0;
            sec_q <= sec_q + 8'h01; // see R3
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ossd <= 1'b0;
        end else begin
            ossd <= (st_q == S_ON) && !kill && !trip; // see R13
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            past_st_q <= 2'h0;
        end else begin
            past_st_q <= st_q;
        end
    end

    // ==========================================================
    // Checks
    property p_inhibit_btn;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q == S_ARM && !restart_btn) |=> st_q != S_ON;
    endproperty
    a_inhibit_btn: assert property (p_inhibit_btn) else $error("restart without button"); // see R1

    property p_nodelay;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q == S_HOLD && mode == RST_NODELAY && clear && !kill && !trip) |=> ##1 ossd;
    endproperty
    a_nodelay: assert property (p_nodelay) else $error("no-delay restart missed"); // see R2

    property p_delay;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q == S_ON && past_st_q == S_DELAY) |-> sec_q == delay_s;
    endproperty
    a_delay: assert property (p_delay) else $error("delay ended early"); // see R3

    property p_fall_cause;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(ossd) |-> $past(kill) || $past(trip) || $past(st_q != S_ON);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("output dropped without cause"); // see R13
endmodule

// [sso_pkg.sv]
// Overview of operation
// R1: Restart-inhibit mode keeps outputs off until field clear and restart pressed.
// R2: No-delay mode re-enables outputs once field clear after multi-scan response.
// R3: Delayed mode re-enables outputs only after set seconds of clear field.
// R4: With startup test on, not ready until field interrupted once after power-on.
// R5: Controller drives the two lines of each control input to opposite levels.
// R6: Logical input value is taken from the second line.
// R7: Case active when all inputs match their low, high or don't-care conditions.
// R8: Output shuts off after 2 to 16 consecutive intruded scans.
// R9: Special vehicle scanner type ignores scan count, response fixed at 270 ms.
// R10: Any-order switchover accepts change to any configured case.
// R11: Unique-order switchover accepts only the single configured successor case.
// R12: Alternative-order switchover accepts only one of two configured successors.
// R13: Each case names one output and only that output is switched off.
// R14: Each case binds one sensor to one area, evaluated from that sensor only.
// R15: Per-output contactor monitoring supervises external feedback when enabled.
// R16: Incremental sensor inputs usable only in vehicle protection.
// R17: Up to 15 monitoring cases.
// R18: Up to eight monitoring areas.
// R19: Pixel suppression ignores objects seen by a single pixel in one scan.
// R20: Equal levels on an input pair is a fault: all outputs off, flag raised.
package sso_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int RESP_FIXED_MS = 270;
    localparam int RESP_CYC_DEF = RESP_FIXED_MS * (CLK_HZ / 1000);
    localparam int SEC_CYC_DEF = CLK_HZ;
    localparam int EDM_WAIT_US = 100;
    localparam int EDM_WAIT_CYC = EDM_WAIT_US * (CLK_HZ / 1_000_000);

    // ==========================================================
    // Sizes
    localparam int CASE_N = 15;
    localparam int AREA_N = 8;
    localparam int SENS_N = 4;
    localparam int IN_N = 4;
    localparam int OUT_N = 2;
    localparam logic [4:0] SCAN_MIN = 5'd2;
    localparam int CASE_W = 29;
    localparam int CTRL_W = 19;
    localparam int STAT_W = 17;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CLR = 8'h08;
    localparam logic [7:0] REG_CASE0 = 8'h40;
    localparam int CLR_IN_FAULT = 0;
    localparam int CLR_ORD_FAULT = 1;
    localparam int CLR_EDM_LO = 2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {RST_INHIBIT, RST_NODELAY, RST_DELAYED, RST_SPARE} sso_restart_t;
    typedef enum logic [1:0] {ORD_ANY, ORD_UNIQUE, ORD_ALT, ORD_SPARE} sso_order_t;

    typedef struct packed {
        logic [7:0] delay_s;
        logic fixed_resp;
        logic start_test;
        sso_restart_t restart;
        logic [1:0] edm_en;
        logic [1:0] out_use;
        logic inc_present;
        logic pix_sup;
        logic vehicle;
    } sso_ctrl_t;

    typedef struct packed {
        logic [3:0] succ2;
        logic [3:0] succ1;
        sso_order_t order;
        logic [3:0] scans_m1;
        logic out_sel;
        logic [2:0] area;
        logic [1:0] sensor;
        logic [3:0] val;
        logic [3:0] care;
        logic en;
    } sso_case_t;

    typedef struct packed {
        logic inc_on;
        logic [3:0] in_lvl;
        logic ready;
        logic [1:0] edm_fault;
        logic [1:0] ossd;
        logic order_fault;
        logic in_fault;
        logic live;
        logic [3:0] act;
    } sso_stat_t;

    typedef struct packed {
        logic vld;
        logic [AREA_N-1:0] multi;
        logic [AREA_N-1:0] hit;
    } sso_scan_t;

    localparam sso_ctrl_t CTRL_RST = sso_ctrl_t'(19'h0);
    localparam sso_case_t CASE_RST = sso_case_t'(29'h0);
endpackage

// [sso_top.sv]
`timescale 1ns/1ns
module sso_top #(
    parameter int RESP_CYC = sso_pkg::RESP_CYC_DEF,
    parameter int SEC_CYC = sso_pkg::SEC_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [sso_pkg::IN_N-1:0] ctl_l1,
    input wire logic [sso_pkg::IN_N-1:0] ctl_l2,
    input sso_pkg::sso_scan_t [sso_pkg::SENS_N-1:0] scan,
    input wire logic restart_btn,
    input wire logic [sso_pkg::OUT_N-1:0] edm_fb,
    input wire logic [1:0] inc_raw,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [sso_pkg::OUT_N-1:0] ossd,
    output logic [1:0] inc_gated,
    output logic fault,
    output logic ready
);
    import sso_pkg::*;

    localparam int RW = $clog2(RESP_CYC + 1);
    localparam int EW = $clog2(EDM_WAIT_CYC + 1);

    // ==========================================================
    // Helpers
    function automatic logic case_hit(sso_case_t c, logic [IN_N-1:0] lvl);
        case_hit = c.en && (((c.val ^ lvl) & c.care) == 4'h0);
    endfunction

    function automatic logic order_ok(sso_case_t c, logic [3:0] nxt);
        unique case (c.order)
            ORD_ANY: order_ok = 1'b1;
            ORD_UNIQUE: order_ok = (nxt == c.succ1);
            ORD_ALT: order_ok = (nxt == c.succ1) || (nxt == c.succ2);
            default: order_ok = 1'b0;
        endcase
    endfunction

    sso_ctrl_t ctrl_q;
    sso_case_t case_q [CASE_N];
    sso_case_t act_cfg;
    sso_scan_t sel_scan;
    sso_stat_t stat;
    logic [IN_N-1:0] in_lvl;
    logic in_bad;
    logic [7:0] case_off;
    logic [5:0] case_idx;
    logic in_case;
    logic [3:0] match_n;
    logic [3:0] act_q;
    logic live;
    logic sw_req;
    logic in_fault_q;
    logic order_fault_q;
    logic [OUT_N-1:0] edm_fault_q;
    logic [4:0] hit_cnt_q;
    logic hit_lvl_q;
    logic tested_q;
    logic [RW-1:0] resp_q;
    logic [4:0] need_n;
    logic scan_hit;
    logic trip;
    logic clear_p;
    logic [OUT_N-1:0] trip_o;
    logic [OUT_N-1:0] clear_o;
    logic [OUT_N-1:0] kill_o;
    logic [EW-1:0] edm_cnt_q [OUT_N];
    logic [3:0] succ1_w;
    logic [3:0] succ2_w;
    logic [1:0] order_w;

    // ==========================================================
    // Control inputs
    assign in_lvl = ctl_l2; // see R6
    assign in_bad = |(~(ctl_l1 ^ ctl_l2)); // see R20

    // ==========================================================
    // Register writes
    assign case_off = reg_addr - REG_CASE0;
    assign case_idx = case_off[7:2];
    assign in_case = (reg_addr >= REG_CASE0) && (case_idx < 6'(CASE_N)) && (reg_addr[1:0] == 2'h0);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_q <= sso_ctrl_t'(reg_wdata[CTRL_W-1:0]);
        end
    end

    // Case table is small enough to live in flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < CASE_N; i++) begin
                case_q[i] <= CASE_RST;
            end
        end else if (reg_wr && in_case) begin
            case_q[case_idx[3:0]] <= sso_case_t'(reg_wdata[CASE_W-1:0]); // see R17
        end
    end

    // ==========================================================
    // Case selection, lowest numbered match wins
    always_comb begin
        match_n = 4'h0;
        for (int i = CASE_N - 1; i >= 0; i--) begin
            if (case_hit(case_q[i], in_lvl)) begin
                match_n = 4'(i + 1); // see R7
            end
        end
    end

    assign act_cfg = (act_q == 4'h0) ? CASE_RST : case_q[act_q - 4'h1];
    assign live = (act_q != 4'h0) && (match_n == act_q);
    assign sw_req = (match_n != 4'h0) && (match_n != act_q);
    assign succ1_w = act_cfg.succ1;
    assign succ2_w = act_cfg.succ2;
    assign order_w = act_cfg.order;

    // First case after reset is taken freely; later ones obey the order
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            act_q <= 4'h0;
        end else if (sw_req && (act_q == 4'h0 || order_ok(act_cfg, match_n))) begin
            act_q <= match_n; // see R10 R11 R12
        end
    end

    // ==========================================================
    // Sticky faults, a new event beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            in_fault_q <= 1'b0;
        end else if (in_bad) begin
            in_fault_q <= 1'b1; // see R20
        end else if (reg_wr && reg_addr == REG_CLR && reg_wdata[CLR_IN_FAULT]) begin
            in_fault_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            order_fault_q <= 1'b0;
        end else if (sw_req && act_q != 4'h0 && !order_ok(act_cfg, match_n)) begin
            order_fault_q <= 1'b1; // see R11 R12
        end else if (reg_wr && reg_addr == REG_CLR && reg_wdata[CLR_ORD_FAULT]) begin
            order_fault_q <= 1'b0;
        end
    end

    // ==========================================================
    // Scan evaluation on the active case's own sensor and area
    assign sel_scan = scan[act_cfg.sensor]; // see R14
    assign scan_hit = sel_scan.hit[act_cfg.area] && (!ctrl_q.pix_sup || sel_scan.multi[act_cfg.area]); // see R19 R18
    assign need_n = (act_cfg.scans_m1 == 4'h0) ? SCAN_MIN : {1'b0, act_cfg.scans_m1} + 5'd1;

    always_ff @(posedge core_clk) begin
        if (!rst_n || sw_req || !live) begin
            hit_cnt_q <= 5'h00;
            hit_lvl_q <= 1'b0;
        end else if (sel_scan.vld) begin
            hit_lvl_q <= scan_hit;
            if (!scan_hit) begin
                hit_cnt_q <= 5'h00;
            end else if (hit_cnt_q != 5'h1f) begin
                hit_cnt_q <= hit_cnt_q + 5'h01; // see R8
            end
        end
    end

    // Fixed response counts time from the first intruded scan
    always_ff @(posedge core_clk) begin
        if (!rst_n || !hit_lvl_q) begin
            resp_q <= '0;
        end else if (resp_q < RW'(RESP_CYC)) begin
            resp_q <= resp_q + 1'b1; // see R9
        end
    end

    // A clear scan outranks the stale count it is about to reset
    assign trip = live && !clear_p && (ctrl_q.vehicle && ctrl_q.fixed_resp
        ? hit_lvl_q && resp_q >= RW'(RESP_CYC) : hit_cnt_q >= need_n); // see R8 R9
    assign clear_p = live && sel_scan.vld && !scan_hit;

    always_comb begin
        for (int k = 0; k < OUT_N; k++) begin
            trip_o[k] = trip && (act_cfg.out_sel == 1'(k)); // see R13
            clear_o[k] = clear_p && (act_cfg.out_sel == 1'(k));
            kill_o[k] = in_bad || in_fault_q || order_fault_q || edm_fault_q[k]
                || !ctrl_q.out_use[k] || !live || !ready; // see R20 R4
        end
    end

    // ==========================================================
    // Startup test
    // Config lands after reset, so ready follows the setting, not a latch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tested_q <= 1'b0;
            ready <= 1'b0;
        end else begin
            tested_q <= tested_q || trip; // see R4
            ready <= !ctrl_q.start_test || tested_q || trip; // see R4
        end
    end

    // ==========================================================
    // Contactor feedback: high while released, low while pulled in
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < OUT_N; k++) begin
            if (!rst_n || !ctrl_q.edm_en[k] || edm_fb[k] != ossd[k]) begin
                edm_cnt_q[k] <= '0;
            end else if (edm_cnt_q[k] < EW'(EDM_WAIT_CYC)) begin
                edm_cnt_q[k] <= edm_cnt_q[k] + 1'b1; // see R15
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int k = 0; k < OUT_N; k++) begin
            if (!rst_n) begin
                edm_fault_q[k] <= 1'b0;
            end else if (edm_cnt_q[k] >= EW'(EDM_WAIT_CYC)) begin
                edm_fault_q[k] <= 1'b1; // see R15
            end else if (reg_wr && reg_addr == REG_CLR && reg_wdata[CLR_EDM_LO + k]) begin
                edm_fault_q[k] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Outputs
    for (genvar g = 0; g < OUT_N; g++) begin : g_out
        sso_out_ctl #(.SEC_CYC(SEC_CYC)) u_out (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .mode(ctrl_q.restart),
            .delay_s(ctrl_q.delay_s),
            .kill(kill_o[g]),
            .trip(trip_o[g]),
            .clear(clear_o[g]),
            .restart_btn(restart_btn),
            .ossd(ossd[g])
        );
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            inc_gated <= 2'h0;
        end else begin
            inc_gated <= inc_raw & {2{ctrl_q.inc_present && ctrl_q.vehicle}}; // see R16
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fault <= 1'b0;
        end else begin
            fault <= in_fault_q || order_fault_q || (|edm_fault_q) || in_bad;
        end
    end

    // ==========================================================
    // Register reads, data valid only in the cycle after the strobe
    always_comb begin
        stat.inc_on = ctrl_q.inc_present && ctrl_q.vehicle;
        stat.in_lvl = in_lvl;
        stat.ready = ready;
        stat.edm_fault = edm_fault_q;
        stat.ossd = ossd;
        stat.order_fault = order_fault_q;
        stat.in_fault = in_fault_q;
        stat.live = live;
        stat.act = act_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == REG_CTRL) begin
            reg_rdata <= 32'(ctrl_q);
        end else if (reg_addr == REG_STAT) begin
            reg_rdata <= 32'(stat);
        end else if (in_case) begin
            reg_rdata <= 32'(case_q[case_idx[3:0]]);
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks
    property p_pair_fault;
        @(posedge core_clk) disable iff (!rst_n)
        in_bad |=> in_fault_q ##1 (ossd == 2'b00);
    endproperty
    a_pair_fault: assert property (p_pair_fault) else $error("pair fault not handled"); // see R20

    property p_live_match;
        @(posedge core_clk) disable iff (!rst_n)
        live |-> act_cfg.en && (((act_cfg.val ^ ctl_l2) & act_cfg.care) == 4'h0);
    endproperty
    a_live_match: assert property (p_live_match) else $error("active case does not match"); // see R7

    property p_unique;
        @(posedge core_clk) disable iff (!rst_n)
        (act_q != 4'h0 && order_w == 2'(ORD_UNIQUE) && !reg_wr)
            |=> (act_q == $past(act_q) || act_q == $past(succ1_w));
    endproperty
    a_unique: assert property (p_unique) else $error("illegal unique switchover"); // see R11

    property p_alt;
        @(posedge core_clk) disable iff (!rst_n)
        (act_q != 4'h0 && order_w == 2'(ORD_ALT) && !reg_wr)
            |=> (act_q == $past(act_q) || act_q == $past(succ1_w) || act_q == $past(succ2_w));
    endproperty
    a_alt: assert property (p_alt) else $error("illegal alternative switchover"); // see R12

    property p_any;
        @(posedge core_clk) disable iff (!rst_n)
        (sw_req && order_w == 2'(ORD_ANY)) |=> act_q == $past(match_n);
    endproperty
    a_any: assert property (p_any) else $error("any-order switchover refused"); // see R10

    property p_scan_count;
        @(posedge core_clk) disable iff (!rst_n)
        (trip && !(ctrl_q.vehicle && ctrl_q.fixed_resp)) |-> hit_cnt_q >= 5'd2;
    endproperty
    a_scan_count: assert property (p_scan_count) else $error("trip below two scans"); // see R8

    property p_fixed;
        @(posedge core_clk) disable iff (!rst_n)
        (trip && ctrl_q.vehicle && ctrl_q.fixed_resp) |-> resp_q == RW'(RESP_CYC);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed response time wrong"); // see R9

    property p_ready;
        @(posedge core_clk) disable iff (!rst_n)
        (ossd != 2'b00) |-> $past(ready);
    endproperty
    a_ready: assert property (p_ready) else $error("output on before startup test"); // see R4

    property p_inc;
        @(posedge core_clk) disable iff (!rst_n)
        (inc_gated != 2'h0) |-> $past(ctrl_q.vehicle);
    endproperty
    a_inc: assert property (p_inc) else $error("incremental input in area mode"); // see R16

    property p_edm;
        @(posedge core_clk) disable iff (!rst_n)
        (edm_cnt_q[0] >= EW'(EDM_WAIT_CYC)) |=> edm_fault_q[0] ##1 !ossd[0];
    endproperty
    a_edm: assert property (p_edm) else $error("contactor fault not latched"); // see R15
endmodule

// [test_scanner_safety_output_control.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin \
    check_count++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("mismatch %0t got %h want %h", $time, a, b); \
    end \
end
module test_scanner_safety_output_control;
    import sso_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic restart_btn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic req = 1'b0;
    logic edm_flip = 1'b0;
    logic fault, ready;
    logic [3:0] lvl = 4'h0;
    logic [3:0] bad = 4'h0;
    logic [3:0] ctl_l1, ctl_l2;
    logic [7:0] req_hit = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [1:0] inc_raw = 2'h3;
    logic [1:0] edm_fb, ossd, inc_gated;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, d;
    sso_scan_t [SENS_N-1:0] scan;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    // ========
    // Contactor follows its output
    assign edm_fb = ~ossd ^ {1'b0, edm_flip};
    sso_top #(.RESP_CYC(40), .SEC_CYC(10)) sso_top_inst (
        .core_clk(core_clk), .rst_n(rst_n), .ctl_l1(ctl_l1), .ctl_l2(ctl_l2),
        .scan(scan), .restart_btn(restart_btn), .edm_fb(edm_fb), .inc_raw(inc_raw),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ossd(ossd), .inc_gated(inc_gated), .fault(fault),
        .ready(ready)
    );
    sso_far_model sso_far_model_inst (
        .core_clk(core_clk), .lvl(lvl), .bad(bad), .req(req), .req_hit(req_hit),
        .ctl_l1(ctl_l1), .ctl_l2(ctl_l2), .scan(scan)
    );
    // ========
    // Clock and hang guard
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            stop_test();
        end
    end
    // ========
    // Bus and stimulus tasks, entered right after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
        v = reg_rdata;
    endtask
    task automatic sc(input logic [7:0] h);
        req <= 1'b1;
        req_hit <= h;
        tick(1);
        req <= 1'b0;
        tick(3);
    endtask
    task automatic stop_test;
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ========
    // Main sequence
    initial begin
        tick(3);
        rst_n <= 1'b1;
        tick(2);
        `CHK({ossd, ready}, 3'b001)
        wr(REG_CTRL, 32'h88);
        wr(REG_CASE0, 32'h8023);
        rd(REG_STAT, d);
        `CHK(d[3:0], 4'h0)
        lvl <= 4'h1;
        tick(3);
        rd(REG_STAT, d);
        `CHK(d[15:0] & 16'hf00f, 16'h1001)
        sc(8'h00);
        tick(3);
        `CHK(ossd, 2'b01)
        sc(8'h02);
        sc(8'h02);
        sc(8'h01);
        `CHK(ossd, 2'b01)
        sc(8'h01);
        tick(3);
        `CHK(ossd, 2'b00)
        sc(8'h00);
        tick(3);
        `CHK(ossd, 2'b01)
        wr(REG_CTRL, 32'h08);
        sc(8'h01);
        sc(8'h01);
        sc(8'h00);
        tick(5);
        `CHK(ossd, 2'b00)
        restart_btn <= 1'b1;
        tick(1);
        restart_btn <= 1'b0;
        tick(3);
        `CHK(ossd, 2'b01)
        wr(REG_CTRL, 32'h1108);
        sc(8'h01);
        sc(8'h01);
        sc(8'h00);
        `CHK(ossd, 2'b00)
        tick(17);
        `CHK(ossd, 2'b00)
        tick(8);
        `CHK(ossd, 2'b01)
        wr(REG_CTRL, 32'h8c);
        tick(2);
        `CHK(inc_gated, 2'b00)
        wr(REG_CTRL, 32'h8d);
        tick(2);
        `CHK(inc_gated, 2'b11)
        bad <= 4'h4;
        tick(3);
        `CHK({fault, ossd}, 3'b100)
        bad <= 4'h0;
        wr(REG_CLR, 32'h1);
        tick(2);
        `CHK(fault, 1'b0)
        wr(REG_CASE0, 32'h488023);
        wr(8'h44, 32'h288045);
        wr(8'h48, 32'h8089);
        lvl <= 4'h2;
        tick(3);
        rd(REG_STAT, d);
        `CHK({fault, d[3:0]}, 5'h02)
        lvl <= 4'h4;
        tick(3);
        rd(REG_STAT, d);
        `CHK({ossd, fault, d[6], d[3:0]}, 8'h32)
        wr(8'h44, 32'h6308045);
        wr(REG_CLR, 32'h2);
        rd(REG_STAT, d);
        `CHK({fault, d[6], d[3:0]}, 6'h03)
        wr(REG_CTRL, 32'h48d);
        sc(8'h00);
        sc(8'h01);
        tick(30);
        `CHK(ossd, 2'b01)
        tick(20);
        `CHK(ossd, 2'b00)
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        lvl <= 4'h1;
        tick(2);
        wr(REG_CTRL, 32'h298);
        wr(REG_CASE0, 32'h8023);
        sc(8'h00);
        tick(3);
        `CHK({ossd, ready}, 3'b000)
        sc(8'h01);
        sc(8'h01);
        sc(8'h00);
        tick(3);
        `CHK({ossd, ready}, 3'b011)
        wr(REG_CTRL, 32'h2b8);
        edm_flip <= 1'b1;
        tick(2495);
        `CHK(fault, 1'b0)
        tick(10);
        `CHK({fault, ossd}, 3'b100)
        stop_test();
    end
endmodule
